/* File: inc/mbcr_defines.svh */
`ifndef MBCR_DEFINES_SVH
`define MBCR_DEFINES_SVH
// ----------------------------------------------------------------
// protocol constants
// ----------------------------------------------------------------
`define MBCR_TCP_PORT 16'd502
`define MBCR_FC_RD_COILS 8'h01
`define MBCR_FC_RD_DISC 8'h02
`define MBCR_FC_RD_HOLD 8'h03
`define MBCR_FC_RD_INREG 8'h04
`define MBCR_FC_WR_COIL 8'h05
`define MBCR_FC_WR_REG 8'h06
`define MBCR_FC_RD_EXC 8'h07
`define MBCR_FC_WR_COILS 8'h0f
`define MBCR_FC_WR_REGS 8'h10
`define MBCR_EXC_FLAG 8'h80
`define MBCR_EXC_ILL_FUNC 8'h01
`define MBCR_EXC_ILL_ADDR 8'h02
`define MBCR_ADDR_MAX 16'h000f
`define MBCR_QTY_MIN 16'h0001
`define MBCR_QTY_MAX 16'h0010
`define MBCR_HDR_LEN 4'h7
`define MBCR_POINT_SCALE 16'd1000
`define MBCR_RAW_ADDR 8'hff
`endif

/* File: inc/mbcr_pkg.sv */
package mbcr_pkg;
  // ----------------------------------------------------------------
  // server states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MBCR_IDLE = 4'b0001,
    MBCR_RECV = 4'b0010,
    MBCR_EVAL = 4'b0100,
    MBCR_SEND = 4'b1000
  } mbcr_state_t;
endpackage

/* File: logic/mbcr_client.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mbcr_defines.svh"
module mbcr_client
  import mbcr_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // async reset
  input wire logic issue, // modbus_issue_request pulse
  input wire logic raw_mode, // send caller bytes verbatim
  input wire logic [7:0] raw_len, // raw byte count
  input wire logic [7:0] raw_byte, // raw byte at raw_idx
  output logic [7:0] raw_idx, // raw array index
  input wire logic [2:0] handle, // handle index, 0 = A
  input wire logic unit_given, // unit id supplied by caller
  input wire logic [7:0] unit_id, // caller unit id
  input wire logic [7:0] func, // function code
  input wire logic [15:0] start, // first point
  input wire logic [15:0] qty, // point count
  output logic [7:0] tx_data, // client byte stream
  output logic tx_valid, // byte valid
  output logic tx_last, // last byte of frame
  input wire logic tx_ready, // sink accepts
  output logic busy, // frame in flight
  input wire logic rsp_valid, // response byte strobe
  input wire logic rsp_first, // byte is function code
  input wire logic [7:0] rsp_byte, // response byte (pdu)
  output logic [7:0] last_func, // last_response_function_query
  output logic [7:0] last_exc // last_exception_code_query
);
  logic [7:0] cnt_r;
  logic [7:0] len_r;
  logic raw_r;
  logic got_func_r;
  logic [7:0] unit_w;
  logic [7:0] pbyte_w;
  logic fire_w;
  // unit id defaults to handle index plus one
  assign unit_w = unit_given ? unit_id : {5'h00, handle} + 8'h01;
  assign fire_w = tx_valid & tx_ready;
  assign raw_idx = cnt_r;
  // parameterised frame: mbap header then read-style pdu
  always_comb begin
    case (cnt_r)
      8'd5: pbyte_w = 8'h06;
      8'd6: pbyte_w = unit_w;
      8'd7: pbyte_w = func;
      8'd8: pbyte_w = start[15:8];
      8'd9: pbyte_w = start[7:0];
      8'd10: pbyte_w = qty[15:8];
      8'd11: pbyte_w = qty[7:0];
      default: pbyte_w = 8'h00;
    endcase
  end
  assign tx_data = raw_r ? raw_byte : pbyte_w;
  assign tx_valid = busy;
  assign tx_last = busy & (cnt_r == len_r - 8'h01);
  // byte sequencing
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      cnt_r <= 8'h00;
      len_r <= 8'h00;
      raw_r <= 1'b0;
    end else if (!busy) begin
      if (issue && !(raw_mode && raw_len == 8'h00)) begin
        busy <= 1'b1;
        cnt_r <= 8'h00;
        raw_r <= raw_mode;
        len_r <= raw_mode ? raw_len : 8'd12;
      end
    end else if (fire_w) begin
      cnt_r <= cnt_r + 8'h01;
      if (tx_last) begin
        busy <= 1'b0;
      end
    end
  end
  // keep function and exception code of last response
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_func <= 8'h00;
      last_exc <= 8'h00;
      got_func_r <= 1'b0;
    end else if (rsp_valid) begin
      got_func_r <= rsp_first;
      if (rsp_first) begin
        last_func <= rsp_byte;
        if (!rsp_byte[7]) begin
          last_exc <= 8'h00;
        end
      end else if (got_func_r && last_func[7]) begin
        last_exc <= rsp_byte;
      end
    end
  end
endmodule
`default_nettype wire

/* File: logic/mbcr_server.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mbcr_defines.svh"
module mbcr_server
  import mbcr_pkg::*;
(
  input wire logic ref_clk, // 125 MHz clock
  input wire logic rst_n, // async reset, low
  input wire logic [15:0] local_port, // tcp port of the session
  input wire logic [7:0] rx_data, // request byte, mbap first
  input wire logic rx_valid, // byte strobe
  input wire logic rx_last, // last byte of request
  output logic rx_ready, // server can take a byte
  output logic [7:0] tx_data, // response byte
  output logic tx_valid, // response byte valid
  output logic tx_last, // last response byte
  input wire logic tx_ready, // sink accepts
  input wire logic [15:0] dout_state, // digital outputs
  input wire logic [15:0] din_state, // digital inputs
  input wire logic analog_function_swap_setting, // swap fc3/fc4
  output logic [7:0] svc_func, // other code passed to handler
  output logic svc_req, // pulse: handler wanted
  output logic svc_analog_out, // handler reads analog outputs
  input wire logic issue, // modbus_issue_request pulse
  input wire logic raw_mode, // raw packet form
  input wire logic [7:0] raw_len, // raw byte count
  input wire logic [7:0] raw_byte, // raw array element
  output logic [7:0] raw_idx, // raw array index
  input wire logic [2:0] handle, // connection_handle_setup index
  input wire logic unit_given, // caller gave unit id
  input wire logic [7:0] unit_id, // caller unit id
  input wire logic [7:0] func, // client function code
  input wire logic [15:0] start, // client start point
  input wire logic [15:0] qty, // client quantity
  input wire logic [15:0] point, // local point number
  output logic [15:0] remote_point, // global i/o number
  output logic [7:0] ctx_data, // client byte stream
  output logic ctx_valid, // client byte valid
  output logic ctx_last, // client last byte
  input wire logic ctx_ready, // client sink accepts
  output logic cbusy, // client frame in flight
  input wire logic rsp_valid, // client response byte strobe
  input wire logic rsp_first, // response function byte
  input wire logic [7:0] rsp_byte, // response byte
  output logic [7:0] last_response_function_query, // last fc
  output logic [7:0] last_exception_code_query // last exception
);
  // ----------------------------------------------------------------
  // request capture
  // ----------------------------------------------------------------
  mbcr_state_t state_r;
  mbcr_state_t state_nxt;
  logic [3:0] rcnt_r;
  logic [7:0] hdr_r [0:3];
  logic [7:0] fc_r;
  logic [15:0] addr_r;
  logic [15:0] qty_r;
  logic [7:0] exc_r;
  logic [15:0] word_r;
  logic [3:0] tcnt_r;
  logic [3:0] tlen_r;
  logic [7:0] tbyte_w;
  logic known_w;
  logic bitread_w;
  logic addr_ok_w;
  logic qty_ok_w;
  logic port_ok_w;
  logic [15:0] src_w;
  logic [15:0] shifted_w;
  logic [15:0] mask_w;
  logic [7:0] bcnt_w;
  logic svc_w;

  // supported codes of the server role; the client role sends func without this check
  function automatic logic fc_known(input logic [7:0] f);
    case (f)
      `MBCR_FC_RD_COILS, `MBCR_FC_RD_DISC, `MBCR_FC_RD_HOLD,
      `MBCR_FC_RD_INREG, `MBCR_FC_WR_COIL, `MBCR_FC_WR_REG,
      `MBCR_FC_RD_EXC, `MBCR_FC_WR_COILS, `MBCR_FC_WR_REGS: begin
        fc_known = 1'b1;
      end
      default: fc_known = 1'b0;
    endcase
  endfunction

  // receive only while collecting a request
  assign rx_ready = (state_r == MBCR_IDLE) || (state_r == MBCR_RECV);

  // header bytes 0-3 are kept for the echo in the reply
  // byte 6 is the unit id and is dropped on purpose
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_r <= 4'h0;
      fc_r <= 8'h00;
      addr_r <= 16'h0000;
      qty_r <= 16'h0000;
      for (int i = 0; i < 4; i++) hdr_r[i] <= 8'h00;
    end else if (rx_valid && rx_ready) begin
      rcnt_r <= rx_last ? 4'h0 : (rcnt_r == 4'hf ? rcnt_r : rcnt_r + 4'h1);
      case (rcnt_r)
        4'd0, 4'd1, 4'd2, 4'd3: hdr_r[rcnt_r[1:0]] <= rx_data;
        4'd7: fc_r <= rx_data;
        4'd8: addr_r[15:8] <= rx_data;
        4'd9: addr_r[7:0] <= rx_data;
        4'd10: qty_r[15:8] <= rx_data;
        4'd11: qty_r[7:0] <= rx_data;
        default: fc_r <= fc_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // request check
  // ----------------------------------------------------------------
  // requests on any other port are dropped without a reply
  assign port_ok_w = (local_port == `MBCR_TCP_PORT);
  assign known_w = fc_known(fc_r);
  // of the known codes, only the two bit reads are answered by this block
  assign bitread_w = (fc_r == `MBCR_FC_RD_COILS) || (fc_r == `MBCR_FC_RD_DISC);
  assign addr_ok_w = (addr_r <= `MBCR_ADDR_MAX);
  // quantity bound, and range must stay inside the 16 points
  assign qty_ok_w = (qty_r >= `MBCR_QTY_MIN) && (qty_r <= `MBCR_QTY_MAX) &&
    ({1'b0, addr_r} + {1'b0, qty_r} <= 17'h10);
  assign svc_w = known_w && !bitread_w;
  // fc3/fc4 target chosen by the swap setting
  assign svc_analog_out = (fc_r == `MBCR_FC_RD_INREG) ^ analog_function_swap_setting;
  assign svc_func = fc_r;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  // digital inputs come from pins and cross into this clock here
  // limitation: reads see the inputs two cycles late
  logic [15:0] din_meta_r;
  logic [15:0] din_sync_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_meta_r <= 16'h0000;
      din_sync_r <= 16'h0000;
    end else begin
      din_meta_r <= din_state;
      din_sync_r <= din_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // status packing
  // ----------------------------------------------------------------
  // pick the bit source, then bring the start point down to bit 0
  assign src_w = (fc_r == `MBCR_FC_RD_DISC) ? din_sync_r : dout_state;
  assign shifted_w = src_w >> addr_r[3:0];
  // ones for each requested point, zero beyond
  assign mask_w = (qty_r[4]) ? 16'hffff : ((16'h0001 << qty_r[3:0]) - 16'h0001);
  assign bcnt_w = (qty_r > 16'h0008) ? 8'h02 : 8'h01;

  // state register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= MBCR_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // whole request taken before evaluation; port check gates service
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      MBCR_IDLE: if (rx_valid) state_nxt = rx_last ? MBCR_EVAL : MBCR_RECV;
      MBCR_RECV: if (rx_valid && rx_last) state_nxt = MBCR_EVAL;
      MBCR_EVAL: state_nxt = (!port_ok_w || svc_w) ? MBCR_IDLE : MBCR_SEND;
      MBCR_SEND: if (tx_valid && tx_ready && tx_last) state_nxt = MBCR_IDLE;
      default: state_nxt = MBCR_IDLE;
    endcase
  end

  // one-cycle pulse; the handler owns the reply for these codes
  assign svc_req = (state_r == MBCR_EVAL) && port_ok_w && svc_w;

  // response fields latched at evaluation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exc_r <= 8'h00;
      word_r <= 16'h0000;
      tlen_r <= 4'h0;
      tcnt_r <= 4'h0;
    end else if (state_r == MBCR_EVAL) begin
      tcnt_r <= 4'h0;
      word_r <= shifted_w & mask_w;
      // exception replies are nine bytes, normal ones nine plus count
      if (!known_w) begin
        exc_r <= `MBCR_EXC_ILL_FUNC;
        tlen_r <= 4'd9;
      end else if (!addr_ok_w || !qty_ok_w) begin
        exc_r <= `MBCR_EXC_ILL_ADDR;
        tlen_r <= 4'd9;
      end else begin
        exc_r <= 8'h00;
        tlen_r <= 4'd9 + bcnt_w[3:0];
      end
    end else if (tx_valid && tx_ready) begin
      // back to zero at frame end so the next frame opens on byte 0
      tcnt_r <= tx_last ? 4'h0 : tcnt_r + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // response framing
  // ----------------------------------------------------------------
  // length = unit id + pdu bytes
  // bytes 9 and 10 only exist in normal coil or input replies
  always_comb begin
    case (tcnt_r)
      4'd0, 4'd1, 4'd2, 4'd3: tbyte_w = hdr_r[tcnt_r[1:0]];
      4'd4: tbyte_w = 8'h00;
      4'd5: tbyte_w = {4'h0, tlen_r} - {4'h0, `MBCR_HDR_LEN} + 8'h01;
      4'd6: tbyte_w = 8'h00;
      4'd7: tbyte_w = (exc_r != 8'h00) ? (fc_r | `MBCR_EXC_FLAG) : fc_r;
      4'd8: tbyte_w = (exc_r != 8'h00) ? exc_r : bcnt_w;
      4'd9: tbyte_w = word_r[7:0];
      4'd10: tbyte_w = word_r[15:8];
      default: tbyte_w = 8'h00;
    endcase
  end

  // byte register; the count is back at 0 before valid rises
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_data <= 8'h00;
    end else begin
      tx_data <= tbyte_w;
    end
  end

  // data register lags count by one; valid waits a cycle after eval
  logic tv_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tv_r <= 1'b0;
    end else begin
      tv_r <= (state_nxt == MBCR_SEND) && !(tx_valid && tx_ready && tx_last) &&
        !(tx_valid && tx_ready);
    end
  end
  // the bubble halves throughput but keeps data and count aligned
  assign tx_valid = (state_r == MBCR_SEND) && tv_r;
  assign tx_last = tx_valid && (tcnt_r == tlen_r - 4'h1);

  // ----------------------------------------------------------------
  // client side
  // ----------------------------------------------------------------
  // i/o numbering for points reached through a client handle
  assign remote_point = 16'({13'h0, handle} * `MBCR_POINT_SCALE) + point;

  // client issuing and last-response bookkeeping
  mbcr_client u_client (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .issue(issue),
    .raw_mode(raw_mode),
    .raw_len(raw_len),
    .raw_byte(raw_byte),
    .raw_idx(raw_idx),
    .handle(handle),
    .unit_given(unit_given),
    .unit_id(unit_id),
    .func(func),
    .start(start),
    .qty(qty),
    .tx_data(ctx_data),
    .tx_valid(ctx_valid),
    .tx_last(ctx_last),
    .tx_ready(ctx_ready),
    .busy(cbusy),
    .rsp_valid(rsp_valid),
    .rsp_first(rsp_first),
    .rsp_byte(rsp_byte),
    .last_func(last_response_function_query),
    .last_exc(last_exception_code_query)
  );
endmodule
`default_nettype wire

/* File: verification/mbcr_server_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module mbcr_server_checker (
  input wire logic ref_clk, // clock
  input wire logic rst_n, // reset
  input wire logic [15:0] local_port, // session port
  input wire logic [7:0] rx_data, // request byte
  input wire logic rx_valid, // request strobe
  input wire logic rx_last, // request end
  input wire logic rx_ready, // server takes
  input wire logic [7:0] tx_data, // reply byte
  input wire logic tx_valid, // reply valid
  input wire logic tx_last, // reply end
  input wire logic tx_ready, // sink takes
  input wire logic analog_function_swap_setting, // swap
  input wire logic [7:0] svc_func, // handler code
  input wire logic svc_req, // handler pulse
  input wire logic svc_analog_out, // handler target
  input wire logic [2:0] handle, // client handle
  input wire logic [15:0] point, // local point
  input wire logic [15:0] remote_point, // global point
  input wire logic rsp_valid, // response strobe
  input wire logic rsp_first, // function byte
  input wire logic [7:0] rsp_byte, // response byte
  input wire logic [7:0] last_response_function_query, // last fc
  input wire logic [7:0] last_exception_code_query // last code
);
  // ----------------------------------------------------------------
  // request tracking
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] cnt_r;
  logic [7:0] fc_r;
  wire acc = rx_valid && rx_ready;
  // fc 3..7, 15, 16 go to the handler and get no reply here
  wire to_svc = (fc_r inside {8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0f, 8'h10});
  // byte 7 of the frame is the function code, after the 7-byte header
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 4'h0;
      fc_r <= 8'h00;
    end else if (acc) begin
      cnt_r <= rx_last ? 4'h0 : cnt_r + ((cnt_r == 4'hf) ? 4'h0 : 4'h1);
      if (cnt_r == 4'h7) fc_r <= rx_data;
    end
  end
  reply_lat_a: assert property (acc && rx_last && local_port == 16'd502 && !to_svc |=> !tx_valid ##1 tx_valid) else $error("reply not two cycles after request");
  port_filter_a: assert property (acc && rx_last && local_port != 16'd502 |=> !tx_valid [*6]) else $error("reply on foreign port");
  byte_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("reply byte dropped");
  frame_end_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid [*2]) else $error("reply runs past last");
  svc_pulse_a: assert property (svc_req |=> !svc_req) else $error("handler pulse too long");
  analog_swap_a: assert property (svc_req && svc_func inside {8'h03, 8'h04} |-> svc_analog_out == ((svc_func == 8'h04) ^ analog_function_swap_setting)) else $error("analog target wrong");
  point_map_a: assert property (remote_point == 16'(16'(handle) * 16'd1000 + point)) else $error("remote point wrong");
  last_func_a: assert property (rsp_valid && rsp_first |=> last_response_function_query == $past(rsp_byte)) else $error("last function not kept");
  exc_clear_a: assert property (rsp_valid && rsp_first && !rsp_byte[7] |=> last_exception_code_query == 8'h00) else $error("exception code stale");
  cover property (svc_req);
  cover property (tx_valid && tx_ready && tx_last);
  cover property (rsp_valid && rsp_first && rsp_byte[7]);
endmodule
bind mbcr_server mbcr_server_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
  .local_port(local_port), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last),
  .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
  .tx_ready(tx_ready), .analog_function_swap_setting(analog_function_swap_setting),
  .svc_func(svc_func), .svc_req(svc_req), .svc_analog_out(svc_analog_out), .handle(handle),
  .point(point), .remote_point(remote_point), .rsp_valid(rsp_valid), .rsp_first(rsp_first),
  .rsp_byte(rsp_byte), .last_response_function_query(last_response_function_query),
  .last_exception_code_query(last_exception_code_query));
`default_nettype wire

/* File: verification/mbcr_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module mbcr_master_model (
  input wire logic ref_clk, // clock
  output logic [7:0] rx_data, // request byte
  output logic rx_valid, // request strobe
  output logic rx_last, // request end
  input wire logic rx_ready, // server takes
  input wire logic [7:0] tx_data, // reply byte
  input wire logic tx_valid, // reply valid
  input wire logic tx_last, // reply end
  output logic tx_ready // we accept
);
  // ----------------------------------------------------------------
  // modbus client on tcp port 502
  // ----------------------------------------------------------------
  logic [7:0] rsp[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    rx_last = 1'b0;
    tx_ready = 1'b0;
  end
  // each byte held until taken; released line shows the inverse, not a stale byte
  task automatic send(input logic [7:0] f[$]);
    foreach (f[i]) begin
      rx_data <= f[i];
      rx_valid <= 1'b1;
      rx_last <= (i == f.size() - 1);
      do @(posedge ref_clk); while (rx_ready !== 1'b1);
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~f[f.size() - 1];
  endtask
  // collect one reply; slow stalls every other cycle
  task automatic recv(input bit slow, input int lim);
    rsp.delete();
    tx_ready <= 1'b1;
    repeat (lim) begin
      @(posedge ref_clk);
      if (tx_valid === 1'b1 && tx_ready) begin
        rsp.push_back(tx_data);
        if (tx_last === 1'b1) break;
      end
      if (slow) tx_ready <= ~tx_ready;
    end
    tx_ready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/modbus_tcp_coil_read_server_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module modbus_tcp_coil_read_server_bench;
  import mbcr_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and checking
  // ----------------------------------------------------------------
  typedef logic [7:0] mbcr_bq_t[$];
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] local_port = 16'd502, dout = 16'h0000, din = 16'h0000, start = 16'h0000;
  logic [15:0] qty = 16'h0000, point = 16'h0000, tid = 16'h0100;
  logic swap = 1'b0, issue = 1'b0, raw_mode = 1'b0, unit_given = 1'b0, ctx_ready = 1'b1;
  logic rsp_valid = 1'b0, rsp_first = 1'b0;
  logic [7:0] raw_len = 8'h00, unit_id = 8'h00, func = 8'h00, rsp_byte = 8'h00;
  logic [2:0] handle = 3'd0;
  logic [7:0] rx_data, tx_data, raw_idx, raw_byte, svc_func, ctx_data, lf, le;
  logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, svc_req, svc_ao;
  logic ctx_valid, ctx_last, cbusy;
  logic [15:0] remote_point;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;
  mbcr_bq_t got;
  always #4 ref_clk = ~ref_clk;
  assign raw_byte = raw_idx ^ 8'ha5; // caller array contents
  mbcr_master_model m (.ref_clk(ref_clk), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready));
  mbcr_server dut (.ref_clk(ref_clk), .rst_n(rst_n), .local_port(local_port),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .dout_state(dout), .din_state(din), .analog_function_swap_setting(swap),
    .svc_func(svc_func), .svc_req(svc_req), .svc_analog_out(svc_ao), .issue(issue),
    .raw_mode(raw_mode), .raw_len(raw_len), .raw_byte(raw_byte), .raw_idx(raw_idx),
    .handle(handle), .unit_given(unit_given), .unit_id(unit_id), .func(func),
    .start(start), .qty(qty), .point(point), .remote_point(remote_point),
    .ctx_data(ctx_data), .ctx_valid(ctx_valid), .ctx_last(ctx_last), .ctx_ready(ctx_ready),
    .cbusy(cbusy), .rsp_valid(rsp_valid), .rsp_first(rsp_first), .rsp_byte(rsp_byte),
    .last_response_function_query(lf), .last_exception_code_query(le));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmp(input mbcr_bq_t e, input mbcr_bq_t s);
    chk("frame length", 16'(e.size()), 16'(s.size()));
    foreach (e[i]) if (i < s.size()) chk("frame byte", {8'h00, e[i]}, {8'h00, s[i]});
  endtask
  // request frame: header, unit, fc, start, quantity
  function automatic mbcr_bq_t req(input logic [7:0] fc, input logic [15:0] sa, input logic [15:0] q);
    return {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h06, 8'h5a, fc, sa[15:8], sa[7:0], q[15:8], q[7:0]};
  endfunction
  // expected reply, packed from the state word
  function automatic mbcr_bq_t rsp(input logic [7:0] fc, input logic [15:0] sa, input logic [15:0] q, input logic [15:0] st);
    logic [15:0] d;
    mbcr_bq_t h;
    d = (st >> sa) & ((16'h0001 << q) - 16'h0001);
    h = {tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00};
    if (fc != 8'h01 && fc != 8'h02) return {h, 8'h03, 8'h00, fc | 8'h80, 8'h01};
    if (sa > 16'h000f || q == 16'h0000 || q > 16'h0010 || sa + q > 16'h0010) return {h, 8'h03, 8'h00, fc | 8'h80, 8'h02};
    if (q > 16'h0008) return {h, 8'h05, 8'h00, fc, 8'h02, d[7:0], d[15:8]};
    return {h, 8'h04, 8'h00, fc, 8'h01, d[7:0]};
  endfunction
  task automatic t_read(input logic [7:0] fc, input logic [15:0] sa, input logic [15:0] q, input bit slow);
    m.send(req(fc, sa, q));
    m.recv(slow, 200);
    cmp(rsp(fc, sa, q, (fc == 8'h02) ? din : dout), m.rsp);
    tid = tid + 16'h0101;
  endtask
  task automatic t_coils;
    dout <= 16'h7337;
    @(posedge ref_clk);
    t_read(8'h01, 16'h0002, 16'h000c, 1'b0);
    t_read(8'h01, 16'h0000, 16'h0010, 1'b1);
    t_read(8'h01, 16'h000f, 16'h0001, 1'b0);
    t_read(8'h01, 16'h0003, 16'h0005, 1'b1);
    $display("coil reads done");
  endtask
  task automatic t_disc;
    din <= 16'hc35a;
    @(posedge ref_clk);
    t_read(8'h02, 16'h0002, 16'h000c, 1'b0);
    t_read(8'h02, 16'h000e, 16'h0002, 1'b1);
    $display("input reads done");
  endtask
  task automatic t_exc;
    t_read(8'h08, 16'h0000, 16'h0001, 1'b0);
    t_read(8'h2b, 16'h0000, 16'h0001, 1'b1);
    t_read(8'h01, 16'h0010, 16'h0001, 1'b0);
    t_read(8'h01, 16'h0000, 16'h0000, 1'b0);
    t_read(8'h01, 16'h0000, 16'h0011, 1'b0);
    t_read(8'h02, 16'h0008, 16'h0009, 1'b0);
    $display("exceptions done");
  endtask
  task automatic t_port;
    local_port <= 16'd503;
    m.send(req(8'h01, 16'h0000, 16'h0001));
    m.recv(1'b0, 20);
    chk("reply on foreign port", 16'h0000, 16'(m.rsp.size()));
    local_port <= 16'd502;
    t_read(8'h01, 16'h0000, 16'h0004, 1'b0);
    $display("port filter done");
  endtask
  task automatic t_svc;
    logic [7:0] fcs[7] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0f, 8'h10};
    logic seen;
    for (int k = 0; k < 9; k++) begin
      swap <= (k > 6);
      m.send(req(fcs[k % 7], 16'h0000, 16'h0001));
      seen = 1'b0;
      repeat (6) begin
        @(posedge ref_clk);
        if (svc_req === 1'b1) begin
          seen = 1'b1;
          chk("handler code", {8'h00, fcs[k % 7]}, {8'h00, svc_func});
          if (k % 7 < 2) chk("analog target", 16'((k % 7 == 1) ^ (k > 6)), {15'h0000, svc_ao});
        end
      end
      chk("handler pulse", 16'h0001, {15'h0000, seen});
    end
    swap <= 1'b0;
    $display("handler codes done");
  endtask
  task automatic t_client;
    mbcr_bq_t e;
    for (int r = 0; r < 3; r++) begin
      handle <= 3'd1;
      point <= 16'd7;
      func <= 8'h01;
      start <= 16'h0002;
      qty <= 16'h000c;
      raw_mode <= (r == 1);
      unit_given <= (r == 2);
      unit_id <= 8'h33;
      raw_len <= 8'h03;
      issue <= 1'b1;
      @(posedge ref_clk);
      issue <= 1'b0;
      got.delete();
      repeat (60) begin
        @(posedge ref_clk);
        if (ctx_valid === 1'b1 && ctx_ready) got.push_back(ctx_data);
        if (ctx_valid === 1'b1 && ctx_ready && ctx_last === 1'b1) break;
        ctx_ready <= ~ctx_ready;
      end
      ctx_ready <= 1'b1;
      e = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h06, (r == 2) ? 8'h33 : 8'h02,
        8'h01, 8'h00, 8'h02, 8'h00, 8'h0c};
      if (r == 1) e = {8'ha5, 8'ha4, 8'ha7};
      cmp(e, got);
      @(posedge ref_clk);
      chk("client busy", 16'h0000, {15'h0000, cbusy});
    end
    chk("remote point", 16'd1007, remote_point);
    $display("client frames done");
  endtask
  task automatic t_resp;
    mbcr_bq_t s[2] = '{{8'h81, 8'h02}, {8'h01, 8'h01, 8'h0d}};
    foreach (s[j]) begin
      foreach (s[j][i]) begin
        rsp_valid <= 1'b1;
        rsp_first <= (i == 0);
        rsp_byte <= s[j][i];
        @(posedge ref_clk);
      end
      rsp_valid <= 1'b0;
      @(posedge ref_clk);
      chk("last function", {8'h00, s[j][0]}, {8'h00, lf});
      chk("last exception", j ? 16'h0000 : 16'h0002, {8'h00, le});
    end
    $display("response query done");
  endtask
  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard, well above the thousand or so cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_coils();
    t_disc();
    t_exc();
    t_port();
    t_svc();
    t_client();
    t_resp();
    summarize();
  end
endmodule
`default_nettype wire
